// >>> tovi_timer_irq.sv
// tovi_timer_irq: 16-bit timer/event counter with the overflow interrupt path.
// assumes the core gives one-cycle strobes for access, boundary and return.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] software sets direction bit 2 for input
// [RULE2] pull-high stays on in timer input use
// [RULE3] timer mode counts on system clock
// [RULE4] pulse mode counts while level present
// [RULE5] event pin resynchronised before counting
// [RULE6] counter frozen during read or preload write
// [RULE7] run bit starts and stops counter
// [RULE8] software sets mode before run bit
// [RULE9] overflow always sets request flag
// [RULE10] overflow never wakes from power-down
// [RULE11] take irq when global, timer, flag set
// [RULE12] push pc and load vector 08H
// [RULE13] service clears flag and global enable
// [RULE14] requests still recorded during service
// [RULE15] software re-enables global for nesting
// [RULE16] full stack blocks acknowledge
// [RULE17] global enable zero blocks all service
// [RULE18] flag stays until serviced or cleared
// [RULE19] return pops saved program counter
// [RULE20] only program counter saved on entry
// [RULE21] software preloads before enabling counter
// [RULE22] mode decode 10 timer 01 event 11 pulse
// [RULE23] overflow reloads preload, keeps counting
// [RULE24] vector only at instruction boundaries
module tovi_timer_irq
    import tovi_pkg::*;
#(
    parameter int unsigned DEPTH = tovi_pkg::STACK_DEPTH
) (
    input  wire logic                          I_CLK,
    input  wire logic                          I_RESET_N,
    input  wire logic                          I_CE,
    input  wire logic                          I_TIMER_INPUT_PIN,
    input  wire logic                          I_PULL_HIGH_OPTION,
    input  wire logic                          I_PORT_A_DIRECTION_2,
    input  wire logic                          I_MODE_SELECT_HIGH,
    input  wire logic                          I_MODE_SELECT_LOW,
    input  wire logic                          I_EDGE_SELECT,
    input  wire logic                          I_RUN_SET,
    input  wire logic                          I_RUN_CLEAR,
    input  wire logic                          I_COUNT_READ,
    input  wire logic                          I_PRELOAD_WRITE,
    input  wire logic [tovi_pkg::TIMER_WIDTH-1:0] I_PRELOAD_DATA,
    input  wire logic                          I_GLOBAL_IRQ_ENABLE_SET,
    input  wire logic                          I_GLOBAL_IRQ_ENABLE_CLEAR,
    input  wire logic                          I_TIMER_IRQ_ENABLE,
    input  wire logic                          I_REQUEST_CLEAR,
    input  wire logic                          I_POWER_DOWN,
    input  wire logic                          I_INSTR_BOUNDARY,
    input  wire logic [tovi_pkg::PC_WIDTH-1:0] I_NEXT_PC,
    input  wire logic                          I_RETURN,
    input  wire logic                          I_STACK_POP,
    output logic [tovi_pkg::TIMER_WIDTH-1:0]   O_COUNT,
    output logic                               O_TIMER_RUN_BIT,
    output logic                               O_TIMER_OVERFLOW_REQUEST,
    output logic                               O_GLOBAL_IRQ_ENABLE,
    output logic                               O_PIN_PULL_HIGH_EN,
    output logic                               O_VECTOR_LOAD,
    output logic [tovi_pkg::PC_WIDTH-1:0]      O_VECTOR_PC,
    output logic                               O_STACK_FULL,
    output logic                               O_WAKE
);
    import tovi_pkg::*;

    // deeper stacks would need a wider pointer than the core offers
    if (DEPTH < 1 || DEPTH > 8) begin : g_bad_depth
        $error("stack depth must be 1 to 8");
    end

    localparam int unsigned SPW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [TIMER_WIDTH-1:0]        count;
        logic [TIMER_WIDTH-1:0]        preload;
        logic                          run;
        logic                          pin_prev;
        logic                          pulse_seen;
        logic                          flag;
        logic                          gie;
        logic                          pull;
        logic                          vload;
        logic [PC_WIDTH-1:0]           vpc;
        logic [SPW-1:0]                sp;
        logic                          sfull;
        logic [DEPTH-1:0][PC_WIDTH-1:0] stack;
        tovi_irq_state_t               st;
    } tovi_state_t;

    tovi_state_t s_q;
    tovi_state_t s_d;
    logic        pin_s;

    // pin comes from outside: two flops before any logic
    tovi_sync u_pin_sync (
        .i_clk     (I_CLK),
        .i_reset_n (I_RESET_N),
        .i_ce      (I_CE),
        .i_async   (I_TIMER_INPUT_PIN),
        .o_sync    (pin_s)
    );

    // [RULE22] mode decode
    function automatic logic [1:0] mode_of(input logic hi, input logic lo);
        return {hi, lo};
    endfunction

    logic [1:0] mode;
    logic       tick;
    logic       active_lvl;
    logic       ovf;
    logic       take;
    logic       full;

    always_comb begin
        s_d        = s_q;
        mode       = mode_of(I_MODE_SELECT_HIGH, I_MODE_SELECT_LOW);
        tick       = 1'b0;
        ovf        = 1'b0;
        take       = 1'b0;
        active_lvl = pin_s ^ ~I_EDGE_SELECT;
        full       = (s_q.sp == SPW'(DEPTH));
        s_d.vload  = 1'b0;
        s_d.pin_prev = pin_s;
        // [RULE2] pull-high kept while pin is timer input
        s_d.pull   = I_PULL_HIGH_OPTION;
        // [RULE7] run bit control
        if (I_RUN_SET) begin
            s_d.run        = 1'b1;
            s_d.pulse_seen = 1'b0;
        end else if (I_RUN_CLEAR) begin
            s_d.run = 1'b0;
        end
        if (s_q.run) begin
            case (mode)
                // [RULE3] timer mode uses system clock
                MODE_TIMER: tick = 1'b1;
                // [RULE5] synchronised edge counting
                MODE_EVENT: tick = (pin_s != s_q.pin_prev) && (pin_s == ~I_EDGE_SELECT);
                // [RULE4] count while active level present
                MODE_PULSE: begin
                    tick = active_lvl;
                    if (active_lvl) begin
                        s_d.pulse_seen = 1'b1;
                    end else if (s_q.pulse_seen) begin
                        s_d.run = 1'b0;
                    end
                end
                default: tick = 1'b0;
            endcase
        end
        // [RULE6] clock inhibited during access
        if (I_COUNT_READ || I_PRELOAD_WRITE) begin
            tick = 1'b0;
        end
        if (I_PRELOAD_WRITE) begin
            s_d.preload = I_PRELOAD_DATA;
        end
        if (tick) begin
            // [RULE23] reload on overflow
            if (&s_q.count) begin
                ovf       = 1'b1;
                s_d.count = s_q.preload;
            end else begin
                s_d.count = s_q.count + 16'h0001;
            end
        end
        // [RULE18] flag held until serviced or cleared
        if (I_REQUEST_CLEAR) begin
            s_d.flag = 1'b0;
        end
        if (I_GLOBAL_IRQ_ENABLE_SET) begin
            s_d.gie = 1'b1;
        end else if (I_GLOBAL_IRQ_ENABLE_CLEAR) begin
            s_d.gie = 1'b0;
        end
        // [RULE19] return pops saved pc
        if (I_RETURN && s_q.sp != '0) begin
            s_d.vload = 1'b1;
            s_d.vpc   = s_q.stack[s_q.sp - SPW'(1)];
            s_d.sp    = s_q.sp - SPW'(1);
        end else if (I_STACK_POP && s_q.sp != '0) begin
            s_d.sp = s_q.sp - SPW'(1);
        end
        case (s_q.st)
            TOVI_IDLE: begin
                // [RULE11] [RULE17] [RULE16] [RULE24] acceptance gate
                take = I_INSTR_BOUNDARY && s_q.gie && I_TIMER_IRQ_ENABLE
                       && s_q.flag && !full && !I_RETURN && !I_STACK_POP;
                if (take) begin
                    // [RULE12] [RULE20] push only pc, vector 08H
                    s_d.stack[s_q.sp] = I_NEXT_PC;
                    s_d.sp    = s_q.sp + SPW'(1);
                    s_d.vload = 1'b1;
                    s_d.vpc   = TIMER_VECTOR;
                    // [RULE13] clear flag and global enable
                    s_d.flag  = 1'b0;
                    s_d.gie   = 1'b0;
                    s_d.st    = TOVI_ENTER;
                end
            end
            TOVI_ENTER: s_d.st = TOVI_SERVE;
            TOVI_SERVE: begin
                if (I_RETURN) begin
                    s_d.st = TOVI_IDLE;
                end
            end
            default: s_d.st = TOVI_IDLE;
        endcase
        // [RULE9] [RULE14] overflow sets flag, set wins
        if (ovf) begin
            s_d.flag = 1'b1;
        end
        // nesting re-entry allowed from serve once gie is set again
        if (s_q.st == TOVI_SERVE && s_d.st == TOVI_SERVE && s_q.gie && s_q.flag) begin
            s_d.st = TOVI_IDLE;
        end
        // full kept as a flop so the output carries no decode glitch
        s_d.sfull = (s_d.sp == SPW'(DEPTH));
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            s_q       <= '0;
            s_q.count <= COUNT_RESET;
            s_q.st    <= TOVI_IDLE;
        end else if (I_CE) begin
            s_q <= s_d;
        end
    end

    assign O_COUNT                  = s_q.count;
    assign O_TIMER_RUN_BIT          = s_q.run;
    assign O_TIMER_OVERFLOW_REQUEST = s_q.flag;
    assign O_GLOBAL_IRQ_ENABLE      = s_q.gie;
    assign O_PIN_PULL_HIGH_EN       = s_q.pull;
    assign O_VECTOR_LOAD            = s_q.vload;
    assign O_VECTOR_PC              = s_q.vpc;
    assign O_STACK_FULL             = s_q.sfull;
    // [RULE10] overflow never raises wake
    assign O_WAKE                   = 1'b0;

    // [RULE9] overflow sets flag
    a_ovf_sets_flag: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE9]
        I_CE && ovf |=> s_q.flag) else $error("overflow did not set flag");
    // [RULE23] reload
    a_ovf_reloads: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE23]
        I_CE && ovf && !I_PRELOAD_WRITE |=> s_q.count == $past(s_q.preload))
        else $error("no reload on overflow");
    // [RULE6] frozen during count read
    a_access_freeze: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE6]
        I_CE && I_COUNT_READ |=> s_q.count == $past(s_q.count))
        else $error("counter moved during read");
    // [RULE7] stopped when run clear
    a_run_stop: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE7]
        !s_q.run && !I_PRELOAD_WRITE |=> $stable(s_q.count))
        else $error("counter ran while stopped");
    // [RULE3] timer mode steps each clock
    a_timer_counts: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE3]
        I_CE && s_q.run && mode == MODE_TIMER && !I_COUNT_READ && !I_PRELOAD_WRITE
        && !(&s_q.count) |=> s_q.count == $past(s_q.count) + 16'h0001)
        else $error("timer mode did not count");
    // [RULE4] idle level holds count
    a_pulse_level: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE4]
        I_CE && s_q.run && mode == MODE_PULSE && !active_lvl |=> $stable(s_q.count))
        else $error("pulse mode counted off level");
    // [RULE5] count only on synced edge
    a_event_edge: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE5]
        I_CE && s_q.run && mode == MODE_EVENT && pin_s == s_q.pin_prev
        |=> $stable(s_q.count))
        else $error("event mode counted without edge");
    // [RULE2] pull-high follows option
    a_pull_follow: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE2]
        I_CE |=> O_PIN_PULL_HIGH_EN == $past(I_PULL_HIGH_OPTION))
        else $error("pull-high enable lost");
    sequence s_take;
        I_CE && take;
    endsequence
    // [RULE12] vector load
    a_vector_load: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE12]
        s_take |=> O_VECTOR_LOAD && O_VECTOR_PC == 11'h008 && !O_GLOBAL_IRQ_ENABLE)
        else $error("vector not loaded");
    // [RULE13] entry clears flag and gie
    a_take_clears: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE13]
        I_CE && take && !ovf |=> !s_q.flag && !s_q.gie)
        else $error("entry left flag or enable set");
    // [RULE19] return pops one entry
    a_return_pops: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE19]
        I_CE && I_RETURN && s_q.sp != '0
        |=> O_VECTOR_LOAD && s_q.sp == $past(s_q.sp) - SPW'(1))
        else $error("return did not pop");
    // [RULE17] no service with gie low
    a_gie_gate: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE17]
        !s_q.gie |-> !take) else $error("taken with global enable low");
    // [RULE16] full stack blocks
    a_full_block: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE16]
        O_STACK_FULL |-> !take) else $error("taken with stack full");
    // [RULE24] only at boundaries
    a_boundary_only: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE24]
        !I_INSTR_BOUNDARY |-> !take) else $error("taken off boundary");
    // [RULE18] flag holds
    a_flag_hold: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE18]
        I_CE && s_q.flag && !take && !I_REQUEST_CLEAR |=> s_q.flag)
        else $error("flag dropped");
    // [RULE10] no wake
    a_no_wake: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // [RULE10]
        I_POWER_DOWN |-> !O_WAKE) else $error("overflow woke device");
endmodule

// >>> tovi_pkg.sv
// tovi_pkg: constants and types shared by the timer/overflow-interrupt block.
// assumes one 200 MHz system clock and an external core that owns the PC.
package tovi_pkg;
    localparam int unsigned CLK_PERIOD_PS   = 5000;
    localparam int unsigned TIMER_WIDTH     = 16;
    localparam int unsigned PC_WIDTH        = 11;
    localparam int unsigned STACK_DEPTH     = 4;
    localparam logic [10:0] TIMER_VECTOR    = 11'h008;
    localparam int unsigned CTRL_RUN_BIT    = 4;
    localparam int unsigned CTRL_EDGE_BIT   = 3;
    localparam int unsigned CTRL_MODE_HI    = 7;
    localparam int unsigned CTRL_MODE_LO    = 6;
    localparam int unsigned DIR_PIN_BIT     = 2;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [1:0]  MODE_TIMER      = 2'h2;
    localparam logic [1:0]  MODE_EVENT      = 2'h1;
    localparam logic [1:0]  MODE_PULSE      = 2'h3;

    typedef enum logic [2:0] {
        TOVI_IDLE  = 3'h1,
        TOVI_ENTER = 3'h2,
        TOVI_SERVE = 3'h4
    } tovi_irq_state_t;
endpackage

// >>> tovi_sync.sv
// tovi_sync: two-flop synchroniser for a level from outside the clock domain.
// assumes the input is a slow level; pulses shorter than a clock may be lost.
`timescale 1ns/1ps
module tovi_sync (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_ce,
    input  wire logic i_async,
    output logic      o_sync
);
    typedef struct packed {
        logic meta;
        logic stable;
    } tovi_sync_state_t;

    tovi_sync_state_t s_q;
    tovi_sync_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (i_ce) begin
            s_d.meta   = i_async;
            s_d.stable = s_q.meta;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sync = s_q.stable;
endmodule

// >>> tovi_pulse_src.sv
// tovi_pulse_src: pulse source standing on the timer input pin.
// assumes requests arrive on rising edges of the bench clock.
`timescale 1ns/1ps
module tovi_pulse_src (
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic       i_level,
    input  wire logic [7:0] i_len,
    output logic            o_pin
);
    int unsigned left = 0;
    initial o_pin = 1'b0;
    // pin moves off the core clock
    always @(posedge i_clk) begin
        if (i_go) begin
            left  <= i_len;
            o_pin <= #2 i_level;
        end else if (left > 1) begin
            left <= left - 1;
        end else begin
            left  <= 0;
            o_pin <= #2 ~i_level;
        end
    end
endmodule

// >>> tb_top.sv
// tb_top: self-checking bench for the timer overflow interrupt block.
// assumes the pulse source model and a 200 MHz clock.
`timescale 1ns/1ps
module tb_top;
    import tovi_pkg::*;
    logic        clk, rst_n, pullh, mhi, mlo, run_set, run_clr, rd, pw, gie_set, gie_clr;
    logic        tie, req_clr, pdn, bnd, ret, pop, go, pin, edge_sel;
    logic        runb, flag, gie, pull_en, vload, full, wake;
    logic [15:0] pdata, cnt, c0;
    logic [10:0] npc, vpc;
    logic [7:0]  len;
    int          fail_count = 0;
    int          cmp_count = 0;

    tovi_pulse_src SRC (.i_clk(clk), .i_go(go), .i_level(1'b1), .i_len(len), .o_pin(pin));
    tovi_timer_irq #(.DEPTH(2)) DUT (
        .I_CLK(clk), .I_RESET_N(rst_n), .I_CE(1'b1), .I_TIMER_INPUT_PIN(pin),
        .I_PULL_HIGH_OPTION(pullh), .I_PORT_A_DIRECTION_2(1'b1), .I_MODE_SELECT_HIGH(mhi),
        .I_MODE_SELECT_LOW(mlo), .I_EDGE_SELECT(edge_sel), .I_RUN_SET(run_set),
        .I_RUN_CLEAR(run_clr), .I_COUNT_READ(rd), .I_PRELOAD_WRITE(pw),
        .I_PRELOAD_DATA(pdata), .I_GLOBAL_IRQ_ENABLE_SET(gie_set),
        .I_GLOBAL_IRQ_ENABLE_CLEAR(gie_clr), .I_TIMER_IRQ_ENABLE(tie),
        .I_REQUEST_CLEAR(req_clr), .I_POWER_DOWN(pdn), .I_INSTR_BOUNDARY(bnd),
        .I_NEXT_PC(npc), .I_RETURN(ret), .I_STACK_POP(pop), .O_COUNT(cnt),
        .O_TIMER_RUN_BIT(runb), .O_TIMER_OVERFLOW_REQUEST(flag), .O_GLOBAL_IRQ_ENABLE(gie),
        .O_PIN_PULL_HIGH_EN(pull_en), .O_VECTOR_LOAD(vload), .O_VECTOR_PC(vpc),
        .O_STACK_FULL(full), .O_WAKE(wake));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // one-cycle strobe, sampled settled afterwards
    task automatic act(input int k);
        @(posedge clk);
        case (k)
            0: bnd <= 1'b1;
            1: ret <= 1'b1;
            2: pop <= 1'b1;
            3: gie_set <= 1'b1;
            5: req_clr <= 1'b1;
            6: rd <= 1'b1;
            7: run_set <= 1'b1;
            8: run_clr <= 1'b1;
            default: gie_clr <= 1'b1;
        endcase
        cyc(1);
        {bnd, ret, pop, gie_set, req_clr, rd, run_set, run_clr, gie_clr} <= '0;
        #1;
    endtask

    task automatic setup(input logic [1:0] m, input logic [15:0] v, input logic ph);
        @(posedge clk);
        {mhi, mlo} <= m;
        pullh <= ph;
        pw <= 1'b1;
        pdata <= v;
        cyc(1);
        pw <= 1'b0;
        #1;
    endtask

    task automatic take(input logic exp);
        act(0);
        chk(vload, exp);
    endtask

    task automatic get_flag(input int lim);
        act(7);
        for (int i = 0; i < lim && flag !== 1'b1; i++) cyc(1);
        act(8);
        chk(flag, 1'b1);
    endtask

    task automatic src(input logic [7:0] n);
        @(posedge clk);
        len <= n;
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        cyc(n + 8);
        #1;
    endtask

    task automatic t_timer;
        setup(2'b10, 16'hfff0, 1'b1);
        get_flag(70000);
        chk(cnt[15:4], 12'hfff);
        c0 = cnt;
        cyc(5);
        #1;
        chk(cnt, c0);
    endtask

    task automatic t_inhibit;
        // preload near the top so later overflows come within a few cycles
        setup(2'b10, 16'hfff0, 1'b1);
        act(7);
        chk(runb, 1'b1);
        c0 = cnt;
        act(6);
        chk(16'(cnt - c0), 16'h1);
        act(8);
    endtask

    task automatic t_irq;
        @(posedge clk);
        npc <= 11'h123;
        take(1'b0);
        @(posedge clk);
        tie <= 1'b1;
        take(1'b0);
        chk(flag, 1'b1);
        act(3);
        take(1'b1);
        chk(vpc, TIMER_VECTOR);
        chk({flag, gie}, 2'b00);
        get_flag(40);
        take(1'b0);
        act(1);
        chk({vload, vpc}, {1'b1, 11'h123});
        @(posedge clk);
        tie <= 1'b0;
        act(3);
        take(1'b0);
        chk(flag, 1'b1);
        act(5);
        chk(flag, 1'b0);
        act(4);
        chk(gie, 1'b0);
        @(posedge clk);
        tie <= 1'b1;
    endtask

    task automatic t_stack;
        setup(2'b10, 16'hfff0, 1'b1);
        for (int i = 0; i < 3; i++) begin
            get_flag(40);
            act(3);
            take(i < 2);
        end
        chk(full, 1'b1);
        act(2);
        take(1'b1);
    endtask

    task automatic t_pdn;
        @(posedge clk);
        pdn <= 1'b1;
        get_flag(40);
        chk(wake, 1'b0);
        @(posedge clk);
        pdn <= 1'b0;
    endtask

    task automatic t_event;
        setup(2'b01, 16'h0000, 1'b1);
        act(7);
        c0 = cnt;
        repeat (5) src(4);
        chk(16'(cnt - c0), 16'h5);
        chk(pull_en, 1'b1);
        act(8);
    endtask

    task automatic t_pulse;
        // high level selected, so the low idle pin does not count
        @(posedge clk);
        edge_sel <= 1'b1;
        setup(2'b11, 16'h0000, 1'b0);
        act(7);
        c0 = cnt;
        src(12);
        chk(16'(cnt - c0) inside {[10:14]}, 1'b1);
        chk({runb, pull_en}, 2'b00);
    endtask

    initial begin
        {rst_n, pullh, mhi, mlo, run_set, run_clr, rd, pw, gie_set, gie_clr} = '0;
        {tie, req_clr, pdn, bnd, ret, pop, go, edge_sel} = '0;
        {pdata, npc, len} = '0;
        cyc(12);
        rst_n <= 1'b1;
        t_timer;
        t_inhibit;
        t_irq;
        t_stack;
        t_pdn;
        t_event;
        t_pulse;
        give_verdict;
    end

    initial begin
        cyc(90000);
        fail_count++;
        give_verdict;
    end
endmodule
